// file: verilog/spi_eeprom_map.svh
// Constants of the serial EEPROM command and protection front end.
// Assumes inclusion by bare name from the design, checker and bench files.
`ifndef SPI_EEPROM_MAP_SVH
`define SPI_EEPROM_MAP_SVH

// ----------------------------------------------------------------------
// Instruction codes
// ----------------------------------------------------------------------
`define OP_LATCH_SET      8'h06
`define OP_LATCH_CLEAR    8'h04
`define OP_STATUS_READ    8'h05
`define OP_STATUS_WRITE   8'h01
`define OP_MEM_READ       8'h03
`define OP_MEM_WRITE      8'h02

// ----------------------------------------------------------------------
// Status byte layout and reset values
// ----------------------------------------------------------------------
`define ST_PIN_EN_BIT     7
`define ST_ID_SEL_BIT     6
`define ST_ID_LOCK_BIT    4
`define ST_BP_HI_BIT      3
`define ST_BP_LO_BIT      2
`define ST_WEL_BIT        1
`define ST_BUSY_BIT       0
`define BP_NONE           2'h0
`define BP_QUARTER        2'h1
`define BP_HALF           2'h2
`define BP_FULL           2'h3
`define NV_BP_RESET       2'h0
`define NV_PIN_EN_RESET   1'h0
`define NV_LOCK_RESET     1'h0

// ----------------------------------------------------------------------
// Array geometry and timing
// ----------------------------------------------------------------------
`define ARRAY_AW          14
`define ID_PAGE_AW        6
`define PROG_W            23
`define FIFO_DEPTH        8
`define CLK_MHZ           100
`define WRITE_TIME_US     5000
`define WRITE_CYCLES      (`WRITE_TIME_US * `CLK_MHZ)
`define WC_CNT_W          20

`endif

// file: verilog/spi_eeprom_pkg.sv
// Types shared by the serial EEPROM front end.
// Assumes the constants header sits beside it.
package spi_eeprom_pkg;

    // Session phase, one-hot.
    typedef enum logic [3:0] {
        PH_CMD    = 4'h1,
        PH_ADDR   = 4'h2,
        PH_DATA   = 4'h4,
        PH_IGNORE = 4'h8
    } phase_t;

endpackage

// file: verilog/spi_eeprom_command_protect.sv
// Serial command front end of a 16Kx8 EEPROM: instruction decode,
// status register, write protection, write cycle timing, write FIFO.
// Assumes clk_sys is much faster than the serial clock; pins are async.
// ----------------------------------------------------------------------
// How it works
// - Input bits are taken on serial clock rising edges, modes 0 and 3.
// - Output bits change on serial clock falling edges.
// - Chip select high tri-states the output; a write cycle continues.
// - Pause input low freezes shift state and tri-states output.
// - Only six instruction codes are accepted; others are ignored.
// - Latch set 06, latch clear 04, status read 05.
// - First byte is the instruction: status write 01, read 03, write 02.
// - Identification page is used for read and write while selected.
// - Busy bit is high during the write cycle; host cannot write it.
// - Latch set instruction sets the enable latch, clear clears it.
// - Block protect bits pick quarter, half or full protected range.
// - Pin enable with protect pin low blocks status and protected writes.
// - Latch at zero blocks all writes; otherwise per protection.
// - Page select is volatile and clears after a read or write.
// - Page lock once set makes the identification page read-only.
// - Setting select and lock together leaves both unchanged.
// - Status byte: enable, select, 0, lock, bp hi, bp lo, latch, busy.
// - Latch is clear after reset; writes need latch and free range.
// - Latch sets only when select rises right after the set command.
// - Write cycle starts at select rise after a valid write sequence.
// - During a write cycle only status read is obeyed.
// - A 16-bit address follows; only the low 14 bits are used.
// - The enable latch clears when the write cycle completes.
// - Status write alters only bits 2, 3, 4, 6 and 7.
`timescale 1ns/100ps
`include "spi_eeprom_map.svh"

module write_fifo #(
    parameter int WIDTH = `PROG_W,
    parameter int DEPTH = `FIFO_DEPTH
) (
    input  wire logic             clk_sys,
    input  wire logic             rst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0]      wr_q;
    logic [AW:0]      rd_q;

    assign in_ready  = (wr_q - rd_q) != (AW + 1)'(DEPTH);
    assign out_valid = wr_q != rd_q;
    assign out_data  = mem_q[rd_q[AW-1:0]];

    always_ff @(posedge clk_sys) begin
        if (in_valid && in_ready) begin
            mem_q[wr_q[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            if (in_valid && in_ready) begin
                wr_q <= wr_q + 1'b1;
            end
            if (out_valid && out_ready) begin
                rd_q <= rd_q + 1'b1;
            end
        end
    end
endmodule // write_fifo

module spi_eeprom_command_protect #(
    parameter logic [`WC_CNT_W-1:0] WRITE_CYCLES =
        `WC_CNT_W'(`WRITE_CYCLES)
) (
    input  wire logic                    clk_sys,
    input  wire logic                    rst,
    input  wire logic                    cs_n,
    input  wire logic                    sck,
    input  wire logic                    si,
    input  wire logic                    hold_n,
    input  wire logic                    wp_n,
    output logic                         so_o,
    output logic                         so_oe,
    output logic      [`ARRAY_AW-1:0]    mem_rd_addr,
    output logic                         mem_rd_id,
    input  wire logic [7:0]              mem_rd_data,
    output logic                         prog_valid,
    input  wire logic                    prog_ready,
    output logic      [`ARRAY_AW-1:0]    prog_addr,
    output logic                         prog_id,
    output logic      [7:0]              prog_data,
    output logic                         prog_start_q
);
    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    // Order: 4 cs_n, 3 sck, 2 si, 1 hold_n, 0 wp_n.
    logic [4:0] pin_meta_q;
    logic [4:0] pin_sync_q;
    logic       sck_d_q;
    logic       cs_d_q;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pin_meta_q <= 5'h13;
            pin_sync_q <= 5'h13;
            sck_d_q    <= 1'b0;
            cs_d_q     <= 1'b1;
        end else begin
            pin_meta_q <= {cs_n, sck, si, hold_n, wp_n};
            pin_sync_q <= pin_meta_q;
            sck_d_q    <= pin_sync_q[3];
            cs_d_q     <= pin_sync_q[4];
        end
    end

    logic cs_s;
    logic si_s;
    logic hold_s;
    logic wp_s;
    logic run;
    logic sck_rise;
    logic sck_fall;
    logic cs_rise;

    assign cs_s    = pin_sync_q[4];
    assign si_s    = pin_sync_q[2];
    assign hold_s  = pin_sync_q[1];
    assign wp_s    = pin_sync_q[0];
    assign run      = !cs_s && hold_s;
    assign sck_rise = run && pin_sync_q[3] && !sck_d_q;
    assign sck_fall = run && !pin_sync_q[3] && sck_d_q;
    assign cs_rise  = cs_s && !cs_d_q;

    // ------------------------------------------------------------------
    // Status state
    // ------------------------------------------------------------------
    logic       pin_en_q;
    logic       id_sel_q;
    logic       id_lock_q;
    logic [1:0] bp_q;
    logic       wel_q;
    logic       busy_q;
    logic [7:0] status;
    logic       hw_prot;

    assign status = {pin_en_q, id_sel_q, 1'b0, id_lock_q,
                     bp_q, wel_q, busy_q};
    assign hw_prot = pin_en_q && !wp_s;

    // ------------------------------------------------------------------
    // Session parser
    // ------------------------------------------------------------------
    spi_eeprom_pkg::phase_t phase_q;
    spi_eeprom_pkg::phase_t cmd_next;
    logic [2:0]  bit_q;
    logic [7:0]  rx_q;
    logic [7:0]  cmd_q;
    logic [15:0] addr_q;
    logic        addr_hi_q;
    logic        extra_q;
    logic [7:0]  rx_byte;
    logic        byte_done;
    logic        rd_cmd;
    logic        load_out;
    logic        wr_byte;
    logic        wr_ok;
    logic        push_ok;

    assign rx_byte   = {rx_q[6:0], si_s};
    assign byte_done = sck_rise && (bit_q == 3'h7);
    assign rd_cmd    = (cmd_q == `OP_MEM_READ) ||
                       (cmd_q == `OP_STATUS_READ);
    assign load_out  = sck_fall && (phase_q == spi_eeprom_pkg::PH_DATA)
                       && rd_cmd && (bit_q == 3'h0);
    assign wr_byte   = byte_done && (phase_q == spi_eeprom_pkg::PH_DATA)
                       && (cmd_q == `OP_MEM_WRITE);

    always_comb begin
        cmd_next = spi_eeprom_pkg::PH_IGNORE;
        unique case (rx_byte)
            `OP_MEM_READ,
            `OP_MEM_WRITE:    cmd_next = spi_eeprom_pkg::PH_ADDR;
            `OP_STATUS_READ,
            `OP_STATUS_WRITE: cmd_next = spi_eeprom_pkg::PH_DATA;
            default:          cmd_next = spi_eeprom_pkg::PH_IGNORE;
        endcase
        if (busy_q && rx_byte != `OP_STATUS_READ) begin
            cmd_next = spi_eeprom_pkg::PH_IGNORE;
        end
    end

    // session restarts when select is high
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            phase_q   <= spi_eeprom_pkg::PH_CMD;
            bit_q     <= 3'h0;
            rx_q      <= 8'h00;
            cmd_q     <= 8'h00;
            addr_q    <= 16'h0000;
            addr_hi_q <= 1'b0;
            extra_q   <= 1'b0;
        end else if (cs_s) begin
            phase_q   <= spi_eeprom_pkg::PH_CMD;
            bit_q     <= 3'h0;
            cmd_q     <= 8'h00;
            addr_hi_q <= 1'b0;
            extra_q   <= 1'b0;
        end else begin
            if (sck_rise) begin
                bit_q <= bit_q + 3'h1;
                rx_q  <= rx_byte;
            end
            unique case (phase_q)
                spi_eeprom_pkg::PH_CMD: begin
                    if (byte_done) begin
                        cmd_q   <= rx_byte;
                        phase_q <= cmd_next;
                    end
                end
                spi_eeprom_pkg::PH_ADDR: begin
                    if (sck_rise) begin
                        addr_q <= {addr_q[14:0], si_s};
                    end
                    if (byte_done) begin
                        addr_hi_q <= 1'b1;
                        if (addr_hi_q) begin
                            phase_q <= spi_eeprom_pkg::PH_DATA;
                        end
                    end
                end
                spi_eeprom_pkg::PH_DATA: begin
                    if (byte_done) begin
                        extra_q <= 1'b1;
                    end
                    if (wr_byte) begin
                        addr_q[5:0] <= addr_q[5:0] + 6'h01;
                    end else if (load_out && cmd_q == `OP_MEM_READ)
                    begin
                        if (id_sel_q) begin
                            addr_q[5:0] <= addr_q[5:0] + 6'h01;
                        end else begin
                            addr_q[13:0] <= addr_q[13:0] + 14'h0001;
                        end
                    end
                end
                spi_eeprom_pkg::PH_IGNORE: begin
                    if (byte_done) begin
                        extra_q <= 1'b1;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Read path and serial output
    // ------------------------------------------------------------------
    logic [7:0] out_q;
    logic       so_q;
    logic       out_en_q;
    logic [7:0] out_src;

    assign out_src = (cmd_q == `OP_MEM_READ) ? mem_rd_data : status;
    assign mem_rd_id   = id_sel_q;
    assign mem_rd_addr = id_sel_q ? {8'h00, addr_q[5:0]} : addr_q[13:0];

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            out_q    <= 8'h00;
            so_q     <= 1'b0;
            out_en_q <= 1'b0;
        end else if (cs_s) begin
            out_en_q <= 1'b0;
        end else if (load_out) begin
            so_q     <= out_src[7];
            out_q    <= {out_src[6:0], 1'b0};
            out_en_q <= 1'b1;
        end else if (sck_fall && out_en_q) begin
            so_q  <= out_q[7];
            out_q <= {out_q[6:0], 1'b0};
        end
    end

    assign so_o  = so_q;
    assign so_oe = run && out_en_q;

    // ------------------------------------------------------------------
    // Write permission and write FIFO
    // ------------------------------------------------------------------
    logic                wr_any_q;
    logic                sts_got_q;
    logic [7:0]          sts_new_q;
    logic                fifo_in_ready;
    logic                fifo_empty_n;
    logic [`PROG_W-1:0]  fifo_out;

    function automatic logic in_prot(input logic [13:0] a,
                                     input logic [1:0]  bp);
        logic r;
        r = 1'b0;
        unique case (bp)
            `BP_NONE:    r = 1'b0;
            `BP_QUARTER: r = (a[13:12] == 2'h3);
            `BP_HALF:    r = a[13];
            `BP_FULL:    r = 1'b1;
        endcase
        return r;
    endfunction

    assign wr_ok = wel_q && !in_prot(addr_q[13:0], bp_q) &&
                   !(id_sel_q && id_lock_q);
    assign push_ok = wr_byte && wr_ok;

    write_fifo #(
        .WIDTH (`PROG_W),
        .DEPTH (`FIFO_DEPTH)
    ) u_fifo (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .in_valid  (push_ok),
        .in_ready  (fifo_in_ready),
        .in_data   ({id_sel_q, addr_q[13:0], rx_byte}),
        .out_valid (fifo_empty_n),
        .out_ready (prog_ready),
        .out_data  (fifo_out)
    );

    assign prog_valid = fifo_empty_n;
    assign prog_id    = fifo_out[22];
    assign prog_addr  = fifo_out[21:8];
    assign prog_data  = fifo_out[7:0];

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wr_any_q  <= 1'b0;
            sts_got_q <= 1'b0;
            sts_new_q <= 8'h00;
        end else if (cs_s) begin
            wr_any_q  <= 1'b0;
            sts_got_q <= 1'b0;
        end else begin
            if (push_ok && fifo_in_ready) begin
                wr_any_q <= 1'b1;
            end
            if (byte_done && phase_q == spi_eeprom_pkg::PH_DATA &&
                cmd_q == `OP_STATUS_WRITE && !extra_q) begin
                sts_new_q <= rx_byte;
                sts_got_q <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Session-end events
    // ------------------------------------------------------------------
    logic clean_end;
    logic latch_set_cmd_ev;
    logic latch_clear_cmd_ev;
    logic sts_ev;
    logic mem_ev;
    logic rd_ev;
    logic start_ev;
    logic done_ev;
    logic both_id;

    assign clean_end = cs_rise && !extra_q && bit_q == 3'h0 && !busy_q;
    // latch set only at select rise
    assign latch_set_cmd_ev = clean_end && cmd_q == `OP_LATCH_SET;
    assign latch_clear_cmd_ev = clean_end && cmd_q == `OP_LATCH_CLEAR;
    // status write refused under pin protection
    assign sts_ev  = cs_rise && cmd_q == `OP_STATUS_WRITE && sts_got_q &&
                     wel_q && !hw_prot && !busy_q;
    assign mem_ev  = cs_rise && cmd_q == `OP_MEM_WRITE && wr_any_q;
    assign rd_ev   = cs_rise && cmd_q == `OP_MEM_READ &&
                     phase_q == spi_eeprom_pkg::PH_DATA;
    // write cycle starts at select rise
    assign start_ev = sts_ev || mem_ev;
    assign both_id  = sts_new_q[`ST_ID_SEL_BIT] &&
                      sts_new_q[`ST_ID_LOCK_BIT];

    // ------------------------------------------------------------------
    // Status register
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wel_q <= 1'b0;
        end else if (latch_set_cmd_ev) begin
            wel_q <= 1'b1;
        end else if (latch_clear_cmd_ev || done_ev) begin
            wel_q <= 1'b0;
        end
    end

    // only bits 7, 6, 4, 3, 2 written
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pin_en_q  <= `NV_PIN_EN_RESET;
            bp_q      <= `NV_BP_RESET;
            id_lock_q <= `NV_LOCK_RESET;
        end else if (sts_ev) begin
            pin_en_q <= sts_new_q[`ST_PIN_EN_BIT];
            bp_q     <= sts_new_q[`ST_BP_HI_BIT:`ST_BP_LO_BIT];
            if (!both_id) begin
                id_lock_q <= id_lock_q | sts_new_q[`ST_ID_LOCK_BIT];
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            id_sel_q <= 1'b0;
        end else if (sts_ev && !both_id) begin
            id_sel_q <= sts_new_q[`ST_ID_SEL_BIT];
        end else if (mem_ev || rd_ev) begin
            id_sel_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Internal write cycle timer
    // ------------------------------------------------------------------
    logic [`WC_CNT_W-1:0] wc_cnt_q;

    assign done_ev = busy_q && wc_cnt_q == '0 && !fifo_empty_n;

    // busy held for the write cycle
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            busy_q       <= 1'b0;
            wc_cnt_q     <= '0;
            prog_start_q <= 1'b0;
        end else begin
            prog_start_q <= start_ev;
            if (start_ev) begin
                busy_q   <= 1'b1;
                wc_cnt_q <= WRITE_CYCLES - `WC_CNT_W'(1);
            end else if (done_ev) begin
                busy_q <= 1'b0;
            end else if (busy_q && wc_cnt_q != '0) begin
                wc_cnt_q <= wc_cnt_q - `WC_CNT_W'(1);
            end
        end
    end
endmodule // spi_eeprom_command_protect

// file: verif/eeprom_sva.sv
// Pin-level checker of the serial EEPROM front end.
// Assumes it is bound into every spi_eeprom_command_protect.
`timescale 1ns/100ps
`include "spi_eeprom_map.svh"
module eeprom_sva #(
    parameter logic [`WC_CNT_W-1:0] WRITE_CYCLES = 20
) (
    input wire logic                 clk_sys,
    input wire logic                 rst,
    input wire logic                 cs_n,
    input wire logic                 sck,
    input wire logic                 si,
    input wire logic                 hold_n,
    input wire logic                 wp_n,
    input wire logic                 so_o,
    input wire logic                 so_oe,
    input wire logic [`ARRAY_AW-1:0] mem_rd_addr,
    input wire logic                 mem_rd_id,
    input wire logic [7:0]           mem_rd_data,
    input wire logic                 prog_valid,
    input wire logic                 prog_ready,
    input wire logic [`ARRAY_AW-1:0] prog_addr,
    input wire logic                 prog_id,
    input wire logic [7:0]           prog_data,
    input wire logic                 prog_start_q
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence desel_s; cs_n [*4]; endsequence
    sequence paused_s; !hold_n [*4]; endsequence
    sequence lone_s; prog_start_q ##1 !prog_start_q [*8]; endsequence
    out_idle_a: assert property (desel_s |-> !so_oe)
        else $error("output driven while deselected");
    out_pause_a: assert property (paused_s |-> !so_oe)
        else $error("output driven while paused");
    out_edge_a: assert property (
        so_oe && $past(so_oe) && $changed(so_o) |-> !sck)
        else $error("output moved with the clock high");
    start_sel_a: assert property (
        prog_start_q |-> cs_n && $past(cs_n))
        else $error("write cycle began while selected");
    start_once_a: assert property (prog_start_q |-> lone_s)
        else $error("second write cycle while busy");
    head_hold_a: assert property (
        prog_valid && !prog_ready |=> prog_valid &&
        $stable({prog_id, prog_addr, prog_data}))
        else $error("programmer entry changed while stalled");
    push_sel_a: assert property ($rose(prog_valid) |-> !cs_n)
        else $error("entry pushed outside a session");
    id_addr_a: assert property (
        mem_rd_id |-> mem_rd_addr[13:6] == 8'h00)
        else $error("page read address above six bits");
endmodule // eeprom_sva

bind spi_eeprom_command_protect eeprom_sva #(.WRITE_CYCLES(WRITE_CYCLES))
    eeprom_sva_i (.clk_sys(clk_sys), .rst(rst), .cs_n(cs_n), .sck(sck),
    .si(si), .hold_n(hold_n), .wp_n(wp_n), .so_o(so_o), .so_oe(so_oe),
    .mem_rd_addr(mem_rd_addr), .mem_rd_id(mem_rd_id),
    .mem_rd_data(mem_rd_data), .prog_valid(prog_valid),
    .prog_ready(prog_ready), .prog_addr(prog_addr), .prog_id(prog_id),
    .prog_data(prog_data), .prog_start_q(prog_start_q));

// file: verif/spi_host.sv
// Host controller model driving the serial pins in mode (0,0) or (1,1).
// Assumes a 10 ns clk_sys; the serial clock period is 160 ns.
`timescale 1ns/100ps
module spi_host (
    input  wire logic clk_sys,
    input  wire logic so_o,
    input  wire logic so_oe,
    output logic      cs_n,
    output logic      sck,
    output logic      si,
    output logic      hold_n
);
    logic mode3 = 1'b0;

    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        si = 1'b0;
        hold_n = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic frame(input logic sel);
        tick(8);
        cs_n = ~sel;
        // A released data line toggles once at deselect, so it does not hold its last bit.
        if (!sel) si = ~si;
        tick(8);
    endtask
    // mode (1,1) idles the clock high
    task automatic set_mode(input logic m);
        mode3 = m;
        sck   = m;
    endtask
    // msb first, read on the rise
    task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
        for (int b = 7; b >= 0; b--) begin
            if (sck) sck = 1'b0;
            si = tx[b];
            tick(8);
            sck = 1'b1;
            rx[b] = so_oe ? so_o : 1'bx;
            tick(8);
        end
        sck = mode3;
    endtask
    task automatic pause(input int n);
        // Let the device see the last clock fall before pausing.
        tick(8);
        hold_n = 1'b0;
        tick(n);
        hold_n = 1'b1;
    endtask
endmodule // spi_host

// file: verif/tb_top.sv
// Self-checking bench: host model on the pins, array and programmer here.
// Assumes the write cycle is shortened to 600 system clocks.
`timescale 1ns/100ps
`include "spi_eeprom_map.svh"
module tb_top;
    logic                 clk_sys;
    logic                 rst;
    logic                 wp_n;
    logic                 stall;
    logic                 cs_n, sck, si, hold_n, so_o, so_oe;
    logic                 prog_valid, prog_id, prog_start_q, mem_rd_id;
    logic [`ARRAY_AW-1:0] mem_rd_addr, prog_addr;
    logic [7:0]           prog_data, rx;
    logic [7:0]           q[$];
    logic [22:0]          pops[$];
    int                   n_errors = 0;
    int                   checks = 0;

    spi_eeprom_command_protect #(.WRITE_CYCLES(`WC_CNT_W'(600)))
        spi_eeprom_command_protect_i (.clk_sys(clk_sys), .rst(rst),
        .cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n), .wp_n(wp_n),
        .so_o(so_o), .so_oe(so_oe), .mem_rd_addr(mem_rd_addr),
        .mem_rd_id(mem_rd_id),
        .mem_rd_data(mem_rd_addr[7:0] ^ {mem_rd_id, 7'h3C}),
        .prog_valid(prog_valid), .prog_ready(~stall),
        .prog_addr(prog_addr), .prog_id(prog_id), .prog_data(prog_data),
        .prog_start_q(prog_start_q));
    spi_host spi_host_i (.clk_sys(clk_sys), .so_o(so_o), .so_oe(so_oe),
        .cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n));

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        if (prog_valid === 1'b1 && stall === 1'b0)
            pops.push_back({prog_id, prog_addr, prog_data});
    end

    task automatic check(input logic [22:0] seen, input logic [22:0] want);
        checks++;
        if (seen !== want) begin
            n_errors++;
            $display("unexpected at %0t: %h not %h", $time, seen, want);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic sess(input logic [7:0] b[$]);
        spi_host_i.frame(1'b1);
        foreach (b[i]) spi_host_i.xbyte(b[i], rx);
        spi_host_i.frame(1'b0);
    endtask
    task automatic status(input logic [7:0] want);
        sess('{8'h05, 8'h00});
        check(23'(rx), 23'(want));
    endtask
    task automatic wr_status(input logic [7:0] v);
        sess('{8'h06});
        sess('{8'h01, v});
    endtask
    task automatic idle();
        for (int k = 0; k < 12; k++) begin
            sess('{8'h05, 8'h00});
            if (rx[0] === 1'b0) return;
        end
        n_errors++;
        $display("unexpected at %0t: write cycle hung", $time);
        stop_test();
    endtask

    initial begin
        rst = 1'b1;
        wp_n = 1'b1;
        stall = 1'b1;
        repeat (12) @(posedge clk_sys);
        #1 rst = 1'b0;
        status(8'h00);
        sess('{8'h06});
        status(8'h02);
        sess('{8'h04});
        status(8'h00);
        sess('{8'hFF});
        sess('{8'h06, 8'h00});
        status(8'h00);
        $display("test latch done");
        wr_status(8'hFF);
        status(8'h8F);
        idle();
        status(8'h8C);
        wp_n = 1'b0;
        wr_status(8'h00);
        status(8'h8E);
        wp_n = 1'b1;
        wr_status(8'h04);
        idle();
        status(8'h04);
        $display("test status done");
        sess('{8'h06});
        sess('{8'h02, 8'hF0, 8'h00, 8'hA5});
        check(23'(prog_valid), 23'h0);
        sess('{8'h06});
        q = '{8'h02, 8'hC0, 8'h3E};
        for (int i = 0; i < 9; i++) q.push_back(8'(8'hA0 + i));
        sess(q);
        check(23'(prog_valid), 23'h1);
        stall = 1'b0;
        idle();
        check(23'(pops.size()), 23'd8);
        foreach (pops[i])
            check(pops[i], {9'h0, 6'(6'h3E + i), 8'(8'hA0 + i)});
        status(8'h04);
        $display("test write done");
        spi_host_i.frame(1'b1);
        q = '{8'h03, 8'hFF, 8'hFE};
        foreach (q[i]) spi_host_i.xbyte(q[i], rx);
        for (int i = 0; i < 3; i++) begin
            spi_host_i.xbyte(8'h00, rx);
            check(23'(rx), 23'(8'(8'hFE + i) ^ 8'h3C));
            spi_host_i.pause(40);
        end
        spi_host_i.frame(1'b0);
        $display("test read done");
        wr_status(8'h44);
        idle();
        status(8'h44);
        spi_host_i.set_mode(1'b1);
        sess('{8'h03, 8'hFF, 8'hC5, 8'h00});
        check(23'(rx), 23'(8'h05 ^ 8'hBC));
        spi_host_i.set_mode(1'b0);
        status(8'h04);
        $display("test page done");
        stop_test();
    end
endmodule // tb_top
